// ### inc/wprhc_pkg.sv
// Purpose: Shared constants and types for the receiver host-control pin block
// Assumes: 20 MHz core clock, no register bus
// Notes:   Power-good mode and rx state encodings live here

// ****************************************
// Package
// ****************************************
package wprhc_pkg;

	// Power profile selector
	localparam logic       PROFILE_BASELINE = 1'h0;
	localparam logic       PROFILE_EXTENDED = 1'h1;

	// Reset values
	localparam logic       PGOOD_RST        = 1'h0;
	localparam logic       IRQ_N_RST        = 1'h1;
	localparam logic [2:0] SYNC_RST         = 3'h7; // Serial lines idle high, so no false edge after reset
	localparam logic       INHIBIT_RST      = 1'h1; // Refuse a link until the pin is seen low

	// Receiver link states
	typedef enum logic [2:0] {
		WPRHC_IDLE     = 3'b000,
		WPRHC_CONNECT  = 3'b001,
		WPRHC_NEGOT    = 3'b010,
		WPRHC_TRANSFER = 3'b011,
		WPRHC_ENDING   = 3'b100,
		WPRHC_SHARE    = 3'b101
	} wprhc_state_t;

	// Interrupt cause bit positions
	localparam int CAUSE_OVP   = 0;
	localparam int CAUSE_OCP   = 1;
	localparam int CAUSE_OTP   = 2;
	localparam int CAUSE_STATE = 3;
	localparam int CAUSE_W     = 4;

endpackage : wprhc_pkg

// ### rtl/wprhc_pins.sv
// Purpose: Host-facing pin logic of a wireless power receiver
// Assumes: Serial slave core, analog comparators and power-transfer engine sit outside
// Notes:   Open-drain pins are split into in/out/oe; oe is high while pulling low
//
// Overview of operation
// [R1] First open-drain pin carries serial clock; pull-up supplies high.
// [R2] Second open-drain pin carries serial data; device only pulls low.
// [R3] Interrupt pin pulled low for status changes, else released.
// [R4] Interrupt raised on state changes and over-current, voltage, temperature; code raises none on connect-to-negotiate step.
// [R5] Inhibit low enables receive; high refuses connecting to transmitter.
// [R6] Inhibit high during transfer sends end packet; overvoltage protection stays.
// [R7] Power-good output is low by default until its condition.
// [R8] Baseline profile: power-good rises when main regulator enables.
// [R9] Extended profile: power-good at negotiation end, or regulator option.
// [R10] Share enable high starts share transmit when output power appears.
// [R11] External clamp drive follows the internal clamp control.
// [R12] Rectifier at ninety percent threshold engages clamp, raises overvoltage interrupt.
// [R13] Interrupt held until host clears every pending cause.
// [R14] Host treats interrupt as active-low level, reads status serially.
`timescale 1ns/1ps

module wprhc_pins
	import wprhc_pkg::*;
(
	input  wire logic                core_clk,
	input  wire logic                nrst,
	input  wire logic                scl_in,
	output logic                     scl_out,
	output logic                     scl_oe,
	input  wire logic                sda_in,
	output logic                     sda_out,
	output logic                     sda_oe,
	input  wire logic                slave_sda_pull,
	output logic                     slave_scl,
	output logic                     slave_sda,
	output logic                     irq_out_n,
	output logic                     irq_oe,
	input  wire logic                inhibit_pin,
	input  wire logic                share_enable_pin,
	input  wire logic                profile_sel,
	input  wire logic                pgood_on_regulator,
	input  wire logic                tx_detected,
	input  wire logic                negotiation_done,
	input  wire logic                regulator_enabled,
	input  wire logic                transfer_lost,
	input  wire logic                output_power_present,
	input  wire logic                rect_near_ovp,
	input  wire logic                over_current,
	input  wire logic                over_temp,
	input  wire logic [CAUSE_W-1:0] cause_clear,
	output logic [CAUSE_W-1:0]      cause_pending,
	output logic                     power_good_out,
	output logic                     ext_clamp_gate_drive,
	output logic                     internal_clamp,
	output logic                     send_end_packet,
	output logic                     rx_enable,
	output logic                     power_share_mode,
	output logic                     ovp_active
);

	// ****************************************
	// State record
	// ****************************************
	typedef struct packed {
		logic [2:0]         scl_sync;
		logic [2:0]         sda_sync;
		logic [2:0]         inh_sync;
		logic [2:0]         shr_sync;
		logic               inh;
		logic               shr;
		wprhc_state_t       state;
		logic [CAUSE_W-1:0] cause;
		logic               ovp_prev;
		logic               ocp_prev;
		logic               otp_prev;
		logic               irq_n;
		logic               sda_pull;
		logic               pgood;
		logic               clamp;
		logic               end_pkt;
		logic               rx_en;
		logic               share;
	} wprhc_reg_t;

	wprhc_reg_t s_q;
	wprhc_reg_t s_d;

	// Majority-free filter: level moves only when stages two and three agree
	function automatic logic wprhc_filt(input logic [2:0] sync, input logic cur);
		wprhc_filt = (sync[1] == sync[2]) ? sync[2] : cur;
	endfunction : wprhc_filt

	// ****************************************
	// Next-state logic
	// ****************************************
	always_comb begin
		logic state_evt;
		state_evt = 1'b0;
		s_d       = s_q;

		// Pin synchronisers, three stages each
		s_d.scl_sync = {s_q.scl_sync[1:0], scl_in};
		s_d.sda_sync = {s_q.sda_sync[1:0], sda_in};
		s_d.inh_sync = {s_q.inh_sync[1:0], inhibit_pin};
		s_d.shr_sync = {s_q.shr_sync[1:0], share_enable_pin};
		s_d.inh      = wprhc_filt(s_q.inh_sync, s_q.inh);
		s_d.shr      = wprhc_filt(s_q.shr_sync, s_q.shr);

		// Data pin only ever pulled low, never driven high
		s_d.sda_pull = slave_sda_pull; // see [R2]

		// Clamp engages from the ninety percent comparator, regardless of inhibit
		s_d.clamp = rect_near_ovp; // see [R12]
		s_d.end_pkt = 1'b0;

		// Link state machine
		case (s_q.state)
			WPRHC_IDLE: begin
				if (s_q.shr && output_power_present) begin
					s_d.state = WPRHC_SHARE; // see [R10]
					state_evt = 1'b1;
				end else if (!s_q.inh && tx_detected) begin
					s_d.state = WPRHC_CONNECT; // see [R5]
					state_evt = 1'b1;
				end
			end
			WPRHC_CONNECT, WPRHC_NEGOT: begin
				if (s_q.inh || transfer_lost) begin
					s_d.state = WPRHC_IDLE; // see [R5]
					state_evt = 1'b1;
				end else if (s_q.state == WPRHC_CONNECT) begin
					s_d.state = WPRHC_NEGOT;
				end else if (negotiation_done) begin
					s_d.state = WPRHC_TRANSFER;
					state_evt = 1'b1;
				end
			end
			WPRHC_TRANSFER: begin
				if (s_q.inh) begin
					s_d.state   = WPRHC_ENDING; // see [R6]
					s_d.end_pkt = 1'b1; // see [R6]
					state_evt   = 1'b1;
				end else if (transfer_lost) begin
					s_d.state = WPRHC_IDLE;
					state_evt = 1'b1;
				end
			end
			WPRHC_ENDING: begin
				// Stay off until inhibit drops; overvoltage clamp keeps running
				if (!s_q.inh) begin
					s_d.state = WPRHC_IDLE;
					state_evt = 1'b1;
				end
			end
			WPRHC_SHARE: begin
				if (!s_q.shr || !output_power_present) begin
					s_d.state = WPRHC_IDLE;
					state_evt = 1'b1;
				end
			end
			default: s_d.state = WPRHC_IDLE;
		endcase

		s_d.rx_en = !s_q.inh; // see [R5]
		s_d.share = (s_d.state == WPRHC_SHARE); // see [R10]

		// Power-good per profile, low outside negotiation and transfer
		if (s_q.state == WPRHC_TRANSFER || s_q.state == WPRHC_NEGOT) begin
			if (profile_sel == PROFILE_BASELINE || pgood_on_regulator)
				s_d.pgood = regulator_enabled; // see [R8] [R9]
			else
				s_d.pgood = (s_q.state == WPRHC_TRANSFER); // see [R9]
		end else begin
			s_d.pgood = PGOOD_RST; // see [R7]
		end

		// Sticky causes on rising events; set wins over clear
		s_d.ovp_prev = rect_near_ovp;
		s_d.ocp_prev = over_current;
		s_d.otp_prev = over_temp;
		s_d.cause = s_q.cause & ~cause_clear; // see [R13]
		if (rect_near_ovp && !s_q.ovp_prev) s_d.cause[CAUSE_OVP] = 1'b1; // see [R12] [R4]
		if (over_current && !s_q.ocp_prev)  s_d.cause[CAUSE_OCP] = 1'b1; // see [R4]
		if (over_temp && !s_q.otp_prev)     s_d.cause[CAUSE_OTP] = 1'b1; // see [R4]
		if (state_evt)                      s_d.cause[CAUSE_STATE] = 1'b1; // see [R4]

		// Pin low while anything pending
		s_d.irq_n = ~|s_d.cause; // see [R3] [R13]
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			s_q          <= '0;
			s_q.state    <= WPRHC_IDLE;
			s_q.irq_n    <= IRQ_N_RST;
			s_q.scl_sync <= SYNC_RST;
			s_q.sda_sync <= SYNC_RST;
			// Inhibit starts asserted: a pin held high across reset must never let a link form
			s_q.inh_sync <= {3{INHIBIT_RST}};
			s_q.inh      <= INHIBIT_RST;
			s_q.pgood    <= PGOOD_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// ****************************************
	// Outputs, from flip-flops or tied to constants
	// ****************************************
	assign scl_out              = 1'b0; // Clock pin is input-only for a slave; see [R1]
	assign scl_oe               = 1'b0; // see [R1]
	assign sda_out              = 1'b0; // see [R2]
	assign sda_oe               = s_q.sda_pull; // see [R2]
	assign slave_scl            = s_q.scl_sync[2]; // see [R1]
	assign slave_sda            = s_q.sda_sync[2];
	assign irq_out_n            = 1'b0; // see [R3]
	assign irq_oe               = ~s_q.irq_n; // see [R3]
	assign cause_pending        = s_q.cause;
	assign power_good_out       = s_q.pgood;
	assign internal_clamp       = s_q.clamp;
	assign ext_clamp_gate_drive = s_q.clamp; // see [R11]
	assign send_end_packet      = s_q.end_pkt;
	assign rx_enable            = s_q.rx_en;
	assign power_share_mode     = s_q.share;
	assign ovp_active           = 1'b1; // Rectifier protection never gated by inhibit; see [R6]

endmodule : wprhc_pins

// ### bench/wprhc_pins_chk.sv
// Purpose: Port checks on the host pin block
// Assumes: One clock, nrst async low
// Notes:   Bound into every pin block
`timescale 1ns/1ps
// ****
// Checker
// ****
module wprhc_pins_chk
	import wprhc_pkg::*;
(
	input wire logic               core_clk,
	input wire logic               nrst,
	input wire logic               slave_sda_pull,
	input wire logic               sda_oe,
	input wire logic               irq_oe,
	input wire logic [CAUSE_W-1:0] cause_pending,
	input wire logic               rect_near_ovp,
	input wire logic               internal_clamp,
	input wire logic               ext_clamp_gate_drive,
	input wire logic               send_end_packet,
	input wire logic               power_good_out,
	input wire logic               regulator_enabled,
	input wire logic               profile_sel,
	input wire logic               pgood_on_regulator,
	input wire logic               inhibit_pin,
	input wire logic               rx_enable
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	// Inhibit held long enough to pass the filter
	sequence s_inh_held; inhibit_pin [*6]; endsequence
	sequence s_ovp_rise; $rose(rect_near_ovp); endsequence
	chk_sda_lag: assert property (1 |=> sda_oe == $past(slave_sda_pull)) else $error("sda lag");
	chk_irq_level: assert property (irq_oe == (|cause_pending)) else $error("irq level");
	chk_clamp_pair: assert property (ext_clamp_gate_drive == internal_clamp) else $error("clamp pair");
	chk_clamp_lag: assert property (1 |=> internal_clamp == $past(rect_near_ovp)) else $error("clamp");
	chk_ovp_cause: assert property (s_ovp_rise |=> cause_pending[CAUSE_OVP]) else $error("ovp cause");
	chk_end_pulse: assert property (send_end_packet |=> !send_end_packet) else $error("end pulse");
	chk_pgood_low: assert property (!regulator_enabled && (profile_sel == PROFILE_BASELINE || pgood_on_regulator)
		|=> !power_good_out) else $error("pgood");
	chk_rx_refused: assert property (s_inh_held |=> !rx_enable) else $error("rx enable");
endmodule : wprhc_pins_chk

bind wprhc_pins wprhc_pins_chk wprhc_pins_chk_i (.*);

// ### bench/wprhc_host.sv
// Purpose: Host side of the pins
// Assumes: Host only pulls lines low
// Notes:   Released lines rise via pull-up
`timescale 1ns/1ps
// ****
// Host model
// ****
module wprhc_host (
	input wire logic scl_oe,
	input wire logic sda_oe,
	input wire logic irq_oe,
	input wire logic host_scl_low,
	input wire logic host_sda_low,
	output logic     scl_w,
	output logic     sda_w,
	output logic     irq_w
);
	// Wired-and lines, pull-up wins when nobody pulls
	assign scl_w = ~(scl_oe | host_scl_low);
	assign sda_w = ~(sda_oe | host_sda_low);
	assign irq_w = ~irq_oe;
endmodule : wprhc_host

// ### bench/wprhc_pins_bench.sv
// Purpose: Self-checking bench of the pin block
// Assumes: 20 MHz clock, inputs change at falling edge
// Notes:   Fault causes checked through a note queue
`timescale 1ns/1ps
// ****
// Bench
// ****
module wprhc_pins_bench
	import wprhc_pkg::*;
;
	logic core_clk, nrst, scl_in, sda_in, slave_sda_pull, inhibit_pin, share_enable_pin, profile_sel;
	logic pgood_on_regulator, tx_detected, negotiation_done, regulator_enabled, transfer_lost, irq_w;
	logic output_power_present, rect_near_ovp, over_current, over_temp, host_scl_low, host_sda_low;
	logic scl_out, scl_oe, sda_out, sda_oe, slave_scl, slave_sda, irq_out_n, irq_oe, power_good_out;
	logic ext_clamp_gate_drive, internal_clamp, send_end_packet, rx_enable, power_share_mode, ovp_active;
	logic [CAUSE_W-1:0] cause_clear, cause_pending;
	logic [2:0]         prev_c;
	logic [2:0]         exp_q[$];
	int                 n_errors, total_checks, k, m;

	wprhc_pins wprhc_pins_i (.*);
	wprhc_host wprhc_host_i (.scl_oe(scl_oe), .sda_oe(sda_oe), .irq_oe(irq_oe), .host_scl_low(host_scl_low),
		.host_sda_low(host_sda_low), .scl_w(scl_in), .sda_w(sda_in), .irq_w(irq_w));

	initial begin
		core_clk = 0;
		forever #25 core_clk = ~core_clk;
	end

	task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask : cyc

	// Bounded wait, the caller then compares
	task automatic wait_for(ref logic s, input logic v);
		for (k = 0; k < 12 && s !== v; k++) @(negedge core_clk);
	endtask : wait_for

	task automatic final_report;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : final_report

	// Each change of the fault causes takes the oldest note
	always @(negedge core_clk) begin
		if (nrst && cause_pending[2:0] !== prev_c) begin
			chk(cause_pending[2:0], exp_q.size() ? exp_q.pop_front() : prev_c);
			prev_c = cause_pending[2:0];
		end
	end

	// Main sequence; inhibit starts high so no link forms
	initial begin
		{nrst, slave_sda_pull, share_enable_pin, profile_sel, pgood_on_regulator, tx_detected} = '0;
		{negotiation_done, regulator_enabled, transfer_lost, output_power_present, rect_near_ovp} = '0;
		{over_current, over_temp, host_scl_low, host_sda_low, cause_clear, prev_c} = '0;
		inhibit_pin = 1;
		n_errors = 0;
		total_checks = 0;
		k = $urandom(33576);
		cyc(12);
		nrst = 1;
		cyc(4);
		chk(rx_enable, 4'h0);
		chk({scl_out, sda_out, irq_out_n, scl_oe}, 4'h0);
		rect_near_ovp = 1; exp_q.push_back(3'h1); cyc(3);
		chk(ext_clamp_gate_drive, 4'h1);
		chk(irq_w, 4'h0);
		over_current = 1; exp_q.push_back(3'h3); cyc(3);
		over_temp = 1; exp_q.push_back(3'h7); cyc(3);
		cause_clear = 4'h1; exp_q.push_back(3'h6); cyc(1); cause_clear = 4'h0; cyc(2);
		chk(irq_w, 4'h0);
		cause_clear = 4'h6; exp_q.push_back(3'h0); cyc(1); cause_clear = 4'h0; rect_near_ovp = 0; cyc(2);
		chk(irq_w, 4'h1);
		chk(internal_clamp, 4'h0);
		$display("test faults done");
		tx_detected = 1; cyc(8);
		chk(cause_pending[3], 4'h0);
		// Three power-good modes: baseline, extended, extended on regulator
		for (m = 0; m < 3; m++) begin
			profile_sel = (m != 0); pgood_on_regulator = (m == 2); inhibit_pin = 0;
			wait_for(rx_enable, 1); cyc(3);
			chk(rx_enable, 4'h1);
			chk(cause_pending[3], 4'h1);
			chk(power_good_out, 4'h0);
			negotiation_done = 1; cyc(3);
			chk(power_good_out, m == 1);
			regulator_enabled = 1; cyc(3);
			chk(power_good_out, 4'h1);
			inhibit_pin = 1; wait_for(send_end_packet, 1);
			chk(send_end_packet, 4'h1);
			cyc(1); chk({send_end_packet, ovp_active}, 4'h1);
			negotiation_done = 0; regulator_enabled = 0; cause_clear = 4'h8; cyc(1); cause_clear = 4'h0;
		end
		$display("test link done");
		inhibit_pin = 0; tx_detected = 0; output_power_present = 1; cyc(8);
		chk(power_share_mode, 4'h0);
		share_enable_pin = 1; wait_for(power_share_mode, 1);
		chk(power_share_mode, 4'h1);
		output_power_present = 0; cyc(3);
		chk(power_share_mode, 4'h0);
		$display("test share done");
		for (m = 0; m < 16; m++) begin
			{slave_sda_pull, host_scl_low, host_sda_low} = 3'($urandom); cyc(4);
			chk({scl_oe, sda_oe}, {3'h0, slave_sda_pull});
			chk({slave_scl, slave_sda}, {2'h0, ~host_scl_low, ~(slave_sda_pull | host_sda_low)});
		end
		$display("test serial done");
		// Every fault note must have been matched by a cause change
		chk(4'(exp_q.size()), 4'h0);
		final_report();
	end

	// Run needs about 180 cycles
	initial begin
		repeat (3000) @(posedge core_clk);
		n_errors++;
		final_report();
	end
endmodule : wprhc_pins_bench
